// ---- logic/bbfc_top.sv ----
// The AHB-Lite interface to the registers was decided locally.
module bbfc_top #(
  parameter int unsigned ADDR_W = 10
) (
  input logic core_clk, // 125 MHz
  input logic rstn, // Async reset, active low
  input logic hsel, // AHB select
  input logic [ADDR_W-1:0] haddr, // AHB address
  input logic [1:0] htrans, // AHB transfer type
  input logic hwrite, // AHB write
  input logic [2:0] hsize, // AHB size (word only)
  input logic [31:0] hwdata, // AHB write data
  input logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  output logic [31:0] hrdata, // AHB read data
  input logic tx_dens_align_evt, // Density violation or align frame
  input logic tx_multiframe_evt, // Transmit multiframe boundary
  input logic tx_clock_restored_evt, // Transmit clock back
  input logic tx_clock_lost_evt, // Transmit clock gone
  input logic rx_t1_e1_select, // 1 = E1 receive
  input logic rx_esf_mode, // Receiver in ESF
  input logic tx_esf_mode, // Transmitter in ESF
  input logic rx_dl_valid, // Receive data link bit strobe
  input logic rx_dl_bit, // Receive data link bit
  input logic tx_dl_req, // Transmit data link bit request
  output logic tx_dl_bit, // Transmit data link bit
  input logic rx_af_start, // Start of received align frame
  input logic [7:0] rx_af_bits, // First byte of that frame
  output logic irq_out // Interrupt request, active high
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] tx_mask;
    logic [1:0] rx_mask;
    logic [3:0] tx_stat;
    logic [1:0] rx_stat;
    logic rst_bit;
    logic [1:0] clr_sel;
    logic [2:0] filt_sel;
    logic [1:0] clr_app;
    logic [2:0] filt_app;
    logic send_en;
    logic [5:0] tx_code;
    logic [5:0] rx_code;
    logic [7:0] af_cap;
    bbfc_pkg::bbfc_rx_state_t rx_st;
    logic [15:0] sr;
    logic [3:0] slot;
    logic [5:0] cand;
    logic [2:0] run;
    logic [9:0] hist;
    logic [6:0] clr_cnt;
    logic [3:0] tx_cnt;
    logic tx_is_msg;
    logic [5:0] tx_lat;
    logic tx_bit;
    logic irq;
    logic ap_wr;
    logic [7:0] ap_idx;
    logic [31:0] rdata;
  } bbfc_state_t;

  bbfc_state_t q;
  bbfc_state_t d;

  function automatic logic crit_met(input logic [2:0] f, input logic [2:0] run,
                                    input logic [9:0] hist);
    int unsigned ones;
    ones = 0;
    for (int i = 0; i < 10; i++) begin
      ones = ones + int'(hist[i]);
    end
    unique case (f)
      bbfc_pkg::FILT_THREE: crit_met = (run >= 3'd3);
      bbfc_pkg::FILT_FIVE: crit_met = (run >= 3'd5);
      bbfc_pkg::FILT_SEVEN: crit_met = (run >= 3'd7);
      bbfc_pkg::FILT_SEVEN_OF_TEN: crit_met = (ones >= bbfc_pkg::WIN_NEED); // [R8]
      default: crit_met = (run != 3'd0); // [R8] [R23]
    endcase
  endfunction : crit_met

  function automatic logic msg_bit(input logic [3:0] idx, input logic [5:0] code);
    logic [3:0] off;
    off = idx - bbfc_pkg::MSG_DATA_LSB;
    if (idx <= bbfc_pkg::MSG_FLAG_END) begin
      msg_bit = 1'b1;
    end else if (idx == bbfc_pkg::MSG_SEP || idx == bbfc_pkg::MSG_LAST) begin
      msg_bit = 1'b0;
    end else begin
      msg_bit = code[off[2:0]]; // [R14]
    end
  endfunction : msg_bit

  function automatic logic [7:0] read_mux(input bbfc_state_t s, input logic [7:0] idx);
    unique case (idx)
      bbfc_pkg::IDX_RX_CODE_STATUS: read_mux = {6'h00, s.rx_stat};
      bbfc_pkg::IDX_RX_CODE_IRQ_MASK: read_mux = {6'h00, s.rx_mask};
      bbfc_pkg::IDX_TX_EVENT_STATUS: read_mux = {4'h0, s.tx_stat};
      bbfc_pkg::IDX_TX_EVENT_IRQ_MASK: read_mux = {4'h0, s.tx_mask};
      bbfc_pkg::IDX_RX_CODE_CTRL: read_mux = {s.rst_bit, 1'b0, s.clr_sel, s.filt_sel, 1'b0};
      bbfc_pkg::IDX_TX_CODE_CTRL: read_mux = {1'b0, s.send_en, 6'h00};
      bbfc_pkg::IDX_RX_CODE_VALUE: read_mux = {2'h0, s.rx_code};
      bbfc_pkg::IDX_TX_CODE_VALUE: read_mux = {2'h0, s.tx_code};
      bbfc_pkg::IDX_RX_ALIGN_FRAME_CAPTURE: read_mux = s.af_cap;
      default: read_mux = bbfc_pkg::RST_REG;
    endcase
  endfunction : read_mux

  logic hit;
  logic met;
  logic rst_edge;
  logic rx_on;
  logic [5:0] code_in;
  logic [15:0] sr_new;
  logic [3:0] tx_clr;
  logic [1:0] rx_clr;
  logic [1:0] rx_set;
  logic [6:0] clr_limit;
  logic cur_msg;
  logic [5:0] cur_code;
  logic [7:0] wdat;

  assign rx_on = rx_esf_mode && !rx_t1_e1_select; // [R20]
  assign clr_limit = (7'(q.clr_app) + 7'd1) * bbfc_pkg::CLEAR_UNIT; // [R7]
  assign wdat = hwdata[7:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    hit = 1'b0;
    met = 1'b0;
    code_in = 6'h00;
    sr_new = q.sr;
    tx_clr = 4'h0;
    rx_clr = 2'h0;
    rx_set = 2'h0;
    cur_msg = q.tx_is_msg;
    cur_code = q.tx_lat;
    // Address phase; read data is fetched here so it stands in the data phase
    if (hsel && htrans[1] && hready) begin
      d.ap_wr = hwrite;
      d.ap_idx = haddr[ADDR_W-1:2];
      if (!hwrite) begin
        d.rdata = {24'h00_0000, read_mux(q, haddr[ADDR_W-1:2])};
      end
    end else if (hready) begin
      d.ap_wr = 1'b0;
    end
    // Data phase of a write
    if (q.ap_wr) begin
      unique case (q.ap_idx)
        bbfc_pkg::IDX_RX_CODE_STATUS: rx_clr = wdat[1:0]; // [R18]
        bbfc_pkg::IDX_RX_CODE_IRQ_MASK: d.rx_mask = wdat[1:0];
        bbfc_pkg::IDX_TX_EVENT_STATUS: tx_clr = wdat[3:0]; // [R19]
        bbfc_pkg::IDX_TX_EVENT_IRQ_MASK: d.tx_mask = wdat[3:0];
        bbfc_pkg::IDX_RX_CODE_CTRL: begin
          d.rst_bit = wdat[bbfc_pkg::POS_RX_RESET];
          d.clr_sel = wdat[bbfc_pkg::POS_CLEAR_LSB +: 2];
          d.filt_sel = wdat[bbfc_pkg::POS_FILTER_LSB +: 3];
        end
        bbfc_pkg::IDX_TX_CODE_CTRL: d.send_en = wdat[bbfc_pkg::POS_SEND];
        bbfc_pkg::IDX_TX_CODE_VALUE: d.tx_code = wdat[5:0];
        default: begin
        end
      endcase
    end
    // Receive code search, validation and clearing
    if (rx_on && rx_dl_valid) begin
      sr_new = {rx_dl_bit, q.sr[15:1]};
      d.sr = sr_new;
      hit = (sr_new[7:0] == 8'hff) && !sr_new[8] && !sr_new[15];
      code_in = sr_new[14:9]; // [R10]
      unique case (q.rx_st)
        bbfc_pkg::RX_HUNT: begin
          if (hit) begin
            d.cand = code_in;
            d.run = 3'd1;
            d.hist = 10'h001;
            d.slot = 4'h0;
            met = crit_met(q.filt_app, 3'd1, 10'h001);
            d.rx_st = bbfc_pkg::RX_TRACK;
          end
        end
        bbfc_pkg::RX_TRACK: begin
          d.slot = q.slot + 4'h1;
          // Messages repeat every 16 bits once aligned
          if (q.slot == bbfc_pkg::MSG_LAST) begin
            if (hit && code_in == q.cand) begin
              d.run = (q.run == bbfc_pkg::RUN_MAX) ? q.run : q.run + 3'd1;
              d.hist = {q.hist[8:0], 1'b1};
            end else if (hit) begin
              d.cand = code_in;
              d.run = 3'd1;
              d.hist = 10'h001;
            end else begin
              d.run = 3'd0;
              d.hist = {q.hist[8:0], 1'b0};
            end
            met = crit_met(q.filt_app, d.run, d.hist); // [R8]
            if (!met && d.hist == 10'h000) begin
              d.rx_st = bbfc_pkg::RX_HUNT;
            end
          end
        end
        bbfc_pkg::RX_LOCKED: begin
          if (hit && code_in == q.rx_code) begin
            d.clr_cnt = 7'd0;
          end else begin
            d.clr_cnt = q.clr_cnt + 7'd1;
          end
          if (d.clr_cnt == clr_limit) begin
            d.rx_st = bbfc_pkg::RX_HUNT; // [R7]
            d.clr_cnt = 7'd0;
            rx_set[bbfc_pkg::POS_CLEARED] = 1'b1; // [R7] [R18]
          end
        end
        default: d.rx_st = bbfc_pkg::RX_HUNT;
      endcase
      if (met) begin
        d.rx_st = bbfc_pkg::RX_LOCKED;
        d.rx_code = d.cand; // [R10]
        d.clr_cnt = 7'd0;
        rx_set[bbfc_pkg::POS_DETECTED] = 1'b1; // [R11]
      end
    end
    // Only a rising edge of the control bit restarts the receiver
    rst_edge = d.rst_bit && !q.rst_bit; // [R5]
    if (rst_edge) begin
      d.rx_st = bbfc_pkg::RX_HUNT; // [R5]
      d.clr_app = d.clr_sel; // [R6]
      d.filt_app = d.filt_sel; // [R6]
      d.sr = 16'h0000;
      d.run = 3'd0;
      d.hist = 10'h000;
      d.clr_cnt = 7'd0;
      d.slot = 4'h0;
      rx_set = 2'h0;
    end
    // Transmit data link; the mode and code are fixed for a whole message
    if (tx_dl_req) begin
      if (q.tx_cnt == 4'h0) begin
        cur_msg = q.send_en && tx_esf_mode; // [R12]
        cur_code = q.tx_code;
      end
      d.tx_is_msg = cur_msg;
      d.tx_lat = cur_code;
      d.tx_bit = cur_msg ? msg_bit(q.tx_cnt, cur_code) : // [R12] [R14]
                 bbfc_pkg::IDLE_CODE[q.tx_cnt[2:0]]; // [R13]
      if (q.tx_cnt == (cur_msg ? bbfc_pkg::MSG_LAST : bbfc_pkg::IDLE_LAST)) begin
        d.tx_cnt = 4'h0;
      end else begin
        d.tx_cnt = q.tx_cnt + 4'h1;
      end
    end
    // E1 align frame capture
    if (rx_af_start && rx_t1_e1_select) begin
      d.af_cap = rx_af_bits; // [R16] [R17] [R21]
    end
    // Sticky flags: a set in the clearing cycle wins
    d.tx_stat = (q.tx_stat & ~tx_clr) | {tx_dens_align_evt, tx_multiframe_evt,
                                         tx_clock_restored_evt, tx_clock_lost_evt}; // [R19]
    d.rx_stat = (q.rx_stat & ~rx_clr) | rx_set; // [R11] [R18]
    d.irq = |(d.tx_stat & d.tx_mask) | |(d.rx_stat & d.rx_mask); // [R1] [R2] [R3] [R4] [R22]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign tx_dl_bit = q.tx_bit;
  assign irq_out = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mask3_irq: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.tx_stat[3] && q.tx_mask[3]) |-> irq_out) // [R1]
    else $error("Enabled density/align flag without irq");
  a_mask2_irq: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.tx_stat[2] && q.tx_mask[2]) |-> irq_out) // [R2]
    else $error("Enabled multiframe flag without irq");
  a_mask1_irq: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.tx_stat[1] && q.tx_mask[1]) |-> irq_out) // [R3]
    else $error("Enabled clock restored flag without irq");
  a_mask0_irq: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.tx_stat[0] && q.tx_mask[0]) |-> irq_out) // [R4]
    else $error("Enabled clock lost flag without irq");
  a_irq_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    ((q.tx_stat & q.tx_mask) == 4'h0 && (q.rx_stat & q.rx_mask) == 2'h0) |-> !irq_out) // [R22]
    else $error("Irq high with no enabled flag");
  a_reset_edge: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(q.rst_bit) |-> (q.rx_st == bbfc_pkg::RX_HUNT && q.filt_app == q.filt_sel
                          && q.clr_app == q.clr_sel)) // [R5]
    else $error("Receive code reset not applied on rising edge");
  a_settings_held: assert property (@(posedge core_clk) disable iff (!rstn)
    !$rose(q.rst_bit) |-> ($stable(q.filt_app) && $stable(q.clr_app))) // [R6]
    else $error("Filter settings changed without reset");
  a_clear_count: assert property (@(posedge core_clk) disable iff (!rstn)
    ($past(q.rx_st) == bbfc_pkg::RX_LOCKED && q.rx_st == bbfc_pkg::RX_HUNT
     && !$rose(q.rst_bit)) |-> (q.rx_stat[1] && $past(q.clr_cnt) == clr_limit - 7'd1)) // [R7]
    else $error("Code clear at wrong count or without flag");
  a_detect_store: assert property (@(posedge core_clk) disable iff (!rstn)
    ($past(q.rx_st) != bbfc_pkg::RX_LOCKED && q.rx_st == bbfc_pkg::RX_LOCKED)
    |-> (q.rx_stat[0] && q.rx_code == q.cand)) // [R10] [R11]
    else $error("Validated code not stored or flagged");
  a_undef_single: assert property (@(posedge core_clk) disable iff (!rstn)
    (rx_on && rx_dl_valid && hit && q.rx_st == bbfc_pkg::RX_HUNT && q.filt_app >= 3'd5
     && !rst_edge) |=> (q.rx_st == bbfc_pkg::RX_LOCKED)) // [R23]
    else $error("Undefined filter code not single occurrence");
  a_msg_sep_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (tx_dl_req && q.tx_is_msg && q.tx_cnt == bbfc_pkg::MSG_SEP) |=> !tx_dl_bit) // [R12]
    else $error("Message separator bit not zero");
  a_msg_data: assert property (@(posedge core_clk) disable iff (!rstn)
    (tx_dl_req && q.tx_is_msg && q.tx_cnt == bbfc_pkg::MSG_DATA_LSB)
    |=> (tx_dl_bit == $past(q.tx_lat[0]))) // [R14]
    else $error("Code bit 0 not sent first");
  a_idle_pattern: assert property (@(posedge core_clk) disable iff (!rstn)
    (tx_dl_req && !q.send_en && q.tx_cnt == 4'h0) ##1 (tx_dl_req [*7])
    |=> (q.tx_cnt == 4'h0 && !q.tx_is_msg)) // [R13]
    else $error("Idle pattern not eight bits long");
  a_align_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    (rx_af_start && rx_t1_e1_select) |=> (q.af_cap == $past(rx_af_bits))) // [R16] [R17]
    else $error("Align frame byte not captured");
endmodule : bbfc_top

// ---- inc/bbfc_pkg.sv ----
// Function
// R1: Mask bit 3 gates density/align flag
// R2: Mask bit 2 gates multiframe flag
// R3: Mask bit 1 gates clock-restored flag
// R4: Mask bit 0 gates clock-lost flag
// R5: Receive code reset on rising control bit
// R6: New filter settings apply after reset only
// R7: Clear count 16/32/48/64 bits, sets cleared
// R8: Validation filter 1,3,5,7 row, 7/10
// R9: Software avoids receive control in E1
// R10: Validated code stored, bit0 earliest
// R11: Validated code sets detected latched flag
// R12: Send enable repeats programmed code message
// R13: Disabled sending emits idle 01111110 continuously
// R14: Six code bits in 16-bit message, bit0 first
// R15: Software writes transmit control in ESF only
// R16: E1 capture holds first align frame byte
// R17: Capture updates at align frame start
// R18: Cleared flag sets on loss, write-one clears
// R19: Transmit flags latched, write-one clears
// R20: Select bit high means E1 receive
// R21: Normal E1 alignment bits read 0011011
// R22: Irq high while any enabled flag set
// R23: Filter codes 101-111 act as single
package bbfc_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RX_CODE_STATUS = 8'h38;
  localparam logic [7:0] IDX_RX_CODE_IRQ_MASK = 8'h39;
  localparam logic [7:0] IDX_TX_EVENT_STATUS = 8'h3a;
  localparam logic [7:0] IDX_TX_EVENT_IRQ_MASK = 8'h3b;
  localparam logic [7:0] IDX_RX_CODE_CTRL = 8'h40;
  localparam logic [7:0] IDX_TX_CODE_CTRL = 8'h41;
  localparam logic [7:0] IDX_RX_CODE_VALUE = 8'h42;
  localparam logic [7:0] IDX_TX_CODE_VALUE = 8'h43;
  localparam logic [7:0] IDX_RX_ALIGN_FRAME_CAPTURE = 8'h50;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned POS_RX_RESET = 7;
  localparam int unsigned POS_CLEAR_LSB = 4;
  localparam int unsigned POS_FILTER_LSB = 1;
  localparam int unsigned POS_SEND = 6;
  localparam int unsigned POS_DETECTED = 0;
  localparam int unsigned POS_CLEARED = 1;
  localparam logic [7:0] RST_REG = 8'h00;
  // ----------------------------------------------------------------
  // Data link constants
  // ----------------------------------------------------------------
  localparam logic [7:0] IDLE_CODE = 8'h7e;
  localparam logic [3:0] MSG_LAST = 4'hf;
  localparam logic [3:0] IDLE_LAST = 4'h7;
  localparam logic [3:0] MSG_FLAG_END = 4'h7;
  localparam logic [3:0] MSG_SEP = 4'h8;
  localparam logic [3:0] MSG_DATA_LSB = 4'h9;
  localparam logic [6:0] CLEAR_UNIT = 7'h10;
  localparam logic [2:0] RUN_MAX = 3'h7;
  localparam int unsigned WIN_NEED = 7;

  typedef enum logic [2:0] {
    FILT_ONE = 3'b000,
    FILT_THREE = 3'b001,
    FILT_FIVE = 3'b010,
    FILT_SEVEN = 3'b011,
    FILT_SEVEN_OF_TEN = 3'b100
  } bbfc_filter_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_TRACK = 2'b01,
    RX_LOCKED = 2'b10
  } bbfc_rx_state_t;
endpackage : bbfc_pkg

// ---- tb/bbfc_line_model.sv ----
module bbfc_line_model (
  input wire logic core_clk, // Line clock
  output logic rx_dl_valid, // Receive link bit strobe
  output logic rx_dl_bit, // Receive link bit
  output logic tx_dl_req, // Transmit bit request
  input wire logic tx_dl_bit // Transmit link bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Far end of the data link
  // ----------------------------------------------------------------
  initial begin
    rx_dl_valid = 1'b0;
    rx_dl_bit = 1'b0;
    tx_dl_req = 1'b0;
  end

  task automatic send_bits(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx_dl_valid <= 1'b1;
      rx_dl_bit <= v[i];
      @(posedge core_clk);
      rx_dl_valid <= 1'b0;
      // Inverted between strobes so a stale bit cannot pass
      rx_dl_bit <= ~v[i];
    end
  endtask : send_bits

  task automatic send_msg(input logic [5:0] code, input int reps);
    for (int r = 0; r < reps; r++) begin
      send_bits({1'b0, code, 1'b0, 8'hff}, 16);
    end
  endtask : send_msg

  // Back-to-back requests, one bit per cycle, as a framer slot would ask
  task automatic fetch_bits(input int n, output logic [15:0] v);
    v = 16'h0000;
    @(posedge core_clk);
    tx_dl_req <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      if (i == n - 1) begin
        tx_dl_req <= 1'b0;
      end
      @(negedge core_clk);
      v[i] = tx_dl_bit;
    end
  endtask : fetch_bits
endmodule : bbfc_line_model

// ---- tb/bits_boc_and_frame_capture_test.sv ----
module bits_boc_and_frame_capture_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, hsel, hwrite, hreadyout, hresp, irq_out;
  logic rx_t1_e1_select, rx_esf_mode, tx_esf_mode, rx_af_start;
  logic rx_dl_valid, rx_dl_bit, tx_dl_req, tx_dl_bit;
  logic [9:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [3:0] tx_evt, ev;
  logic [7:0] rx_af_bits, seed;
  logic [15:0] bits_v;
  logic [5:0] code;
  int n_mismatch, cmp_count, cyc, tx_status_m, mask_m, clr, n, flt;

  bbfc_top dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_dens_align_evt(tx_evt[3]),
    .tx_multiframe_evt(tx_evt[2]), .tx_clock_restored_evt(tx_evt[1]),
    .tx_clock_lost_evt(tx_evt[0]), .rx_t1_e1_select(rx_t1_e1_select),
    .rx_esf_mode(rx_esf_mode), .tx_esf_mode(tx_esf_mode), .rx_dl_valid(rx_dl_valid),
    .rx_dl_bit(rx_dl_bit), .tx_dl_req(tx_dl_req), .tx_dl_bit(tx_dl_bit),
    .rx_af_start(rx_af_start), .rx_af_bits(rx_af_bits), .irq_out(irq_out));

  bbfc_line_model line (.core_clk(core_clk), .rx_dl_valid(rx_dl_valid),
    .rx_dl_bit(rx_dl_bit), .tx_dl_req(tx_dl_req), .tx_dl_bit(tx_dl_bit));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // No wait count assumed: loop until the slave says ready
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk);
    htrans <= 2'b10;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, idx, d, dummy);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, idx, 32'h0000_0000, v);
    check(v, exp);
  endtask : rd_chk

  task automatic pulse(input logic [3:0] e);
    @(posedge core_clk);
    tx_evt <= e;
    @(posedge core_clk);
    tx_evt <= 4'h0;
    tx_status_m = tx_status_m | int'(e);
  endtask : pulse

  task automatic chk_irq();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check({31'h0, irq_out}, {31'h0, |(tx_status_m[3:0] & mask_m[3:0])});
  endtask : chk_irq

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, hwrite, rx_t1_e1_select, rx_af_start} = 4'h0;
    {hsel, rx_esf_mode, tx_esf_mode} = 3'h7;
    haddr = 10'h000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    tx_evt = 4'h0;
    rx_af_bits = 8'h00;
    seed = 8'h5e;
    {n_mismatch, cmp_count, tx_status_m, mask_m} = '0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    // Read-only and unmapped places must ignore writes
    wr(bbfc_pkg::IDX_RX_CODE_VALUE, 32'h0000_003f);
    wr(8'h7f, 32'h0000_00ff);
    rd_chk(8'h3b, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(8'h41, 32'h0000_0000);
    rd_chk(8'h42, 32'h0000_0000);
    rd_chk(8'h43, 32'h0000_0000);
    rd_chk(8'h50, 32'h0000_0000);
    rd_chk(8'h7f, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      ev = 4'h1 << i;
      pulse(~ev);
      wr(bbfc_pkg::IDX_TX_EVENT_IRQ_MASK, {28'h0, ev});
      mask_m = int'(ev);
      chk_irq();
      pulse(ev);
      chk_irq();
      rd_chk(bbfc_pkg::IDX_TX_EVENT_STATUS, 32'h0000_000f);
      wr(bbfc_pkg::IDX_TX_EVENT_STATUS, 32'h0000_000f);
      tx_status_m = 0;
      chk_irq();
    end
    line.fetch_bits(8, bits_v);
    check({24'h0, bits_v[7:0]}, 32'h0000_007e);
    seed = lfsr(seed);
    code = seed[5:0];
    // Transmitter stays in ESF while these are written
    wr(bbfc_pkg::IDX_TX_CODE_VALUE, {26'h0, code});
    wr(bbfc_pkg::IDX_TX_CODE_CTRL, 32'h0000_0040);
    repeat (2) begin
      line.fetch_bits(16, bits_v);
      check({16'h0, bits_v}, {16'h0, 1'b0, code, 1'b0, 8'hff});
    end
    wr(bbfc_pkg::IDX_TX_CODE_CTRL, 32'h0000_0000);
    line.fetch_bits(8, bits_v);
    check({24'h0, bits_v[7:0]}, 32'h0000_007e);
    // Receiver stays DS1 ESF while its control is written
    for (int f = 0; f < 6; f++) begin
      seed = lfsr(seed);
      code = seed[5:0];
      clr = f % 4;
      // Last pass uses an undefined filter code, which must act as single
      flt = (f < 5) ? f : 5 + int'(seed[7]);
      n = (f == 0 || f == 5) ? 1 : ((f == 4) ? 7 : 2 * f + 1);
      wr(bbfc_pkg::IDX_RX_CODE_CTRL, 32'h0000_0000);
      wr(bbfc_pkg::IDX_RX_CODE_CTRL, 32'h0000_0080 | (clr << 4) | (flt << 1));
      wr(bbfc_pkg::IDX_RX_CODE_STATUS, 32'h0000_0003);
      if (n > 1) begin
        line.send_msg(code, n - 1);
      end
      rd_chk(bbfc_pkg::IDX_RX_CODE_STATUS, 32'h0000_0000);
      line.send_msg(code, 1);
      rd_chk(bbfc_pkg::IDX_RX_CODE_STATUS, 32'h0000_0001);
      rd_chk(bbfc_pkg::IDX_RX_CODE_VALUE, {26'h0, code});
      wr(bbfc_pkg::IDX_RX_CODE_STATUS, 32'h0000_0001);
      line.send_bits(16'h0000, 1);
      for (int j = 2; j < (clr + 1) * 16; j++) begin
        line.send_bits(16'h0000, 1);
      end
      rd_chk(bbfc_pkg::IDX_RX_CODE_STATUS, 32'h0000_0000);
      line.send_bits(16'h0000, 1);
      rd_chk(bbfc_pkg::IDX_RX_CODE_STATUS, 32'h0000_0002);
    end
    rx_t1_e1_select <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      @(posedge core_clk);
      rx_af_start <= 1'b1;
      rx_af_bits <= (k == 2) ? seed : {seed[0], 7'h1b};
      if (k == 2) begin
        rx_t1_e1_select <= 1'b0;
      end
      @(posedge core_clk);
      rx_af_start <= 1'b0;
      rd_chk(bbfc_pkg::IDX_RX_ALIGN_FRAME_CAPTURE, {24'h0, lfsr(seed) == 8'h00 ? 8'h00 :
        (k == 2 ? {code[0], 7'h1b} : {seed[0], 7'h1b})});
      code[0] = seed[0];
    end
    wrap_up();
  end
endmodule : bits_boc_and_frame_capture_test
